/* rtl/dfcfc_pkg.sv */
/*
  Constants and types for the deep fifo configuration and flag control block.
  Assumes a writer on mclk and a reader on its own read clock.
*/
// Summary of operation
// - write enable, serial enable or full reset leaves auto power-down at once; write strobe only after its synchronizer
// - output buffer enabled by async output enable and, outside full reset, read chip select
// - read chip select is sampled on the read clock
// - read timing pin at full reset: high clocked port, low strobe port
// - write timing pin at full reset: high clocked port, low strobe port
// - each write stores a 36-bit word
// - first flag: empty in standard mode, output ready in fall-through
// - second flag: full in standard mode, input ready in fall-through
// - default offset selects plus load pick one of eight offsets
// - load pin at full reset fixes serial or parallel offset loading
// - after full reset, load routes reads and writes to offset registers
// - fall-through pin picks mode in reset, then is serial offset input
// - mark request records the read pointer as replay position
// - replay reloads the read pointer with the recorded position
// - full reset zeroes both pointers and the output register
// - full reset latches zero-latency and almost-flag timing options
// - each flag has two copies, one per half memory
// - flag timing pin at full reset: low async, high sync almost flags
// - almost-empty low while stored count below empty offset
// - almost-full low while free space at or below full offset
package dfcfc_pkg;
  localparam int ADDR_W         = 19;
  localparam int DATA_W         = 36;
  localparam int IDLE_TIME_NS   = 1000;
  localparam int MCLK_PERIOD_NS = 8;
  localparam int IDLE_CYCLES    = (IDLE_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam logic [ADDR_W-1:0] DEF_OFFSET [8] = '{19'h00007, 19'h0000F, 19'h0001F,
    19'h0003F, 19'h0007F, 19'h000FF, 19'h001FF, 19'h003FF};
  localparam logic [DATA_W-1:0] DOUT_RST = 36'h000000000;
  typedef enum logic {MODE_STANDARD, MODE_FALLTHRU} dfcfc_mode_e;
endpackage : dfcfc_pkg

/* rtl/dfcfc_top.sv */
/*
  Deep fifo: configuration latch, pointers, flags, mark/replay, output control.
  Assumes writer logic on mclk, reader logic on readClk; strobes are free-running pins.
*/
`timescale 1ns/1ps
module dfcfc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_reg, s2_reg, s3_reg;
  // three stages; a value counts once the last two agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q      <= '0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) q <= s3_reg;
    end
  end
endmodule : dfcfc_sync

module dfcfc_top #(
  parameter int AW = dfcfc_pkg::ADDR_W
) (
  input  wire logic                         mclk,
  input  wire logic                         reset_n,
  input  wire logic                         clkEn,
  input  wire logic                         readClk,
  input  wire logic                         fullReset_n,
  input  wire logic                         readPortTimingSel,
  input  wire logic                         writePortTimingSel,
  input  wire logic                         defaultOffsetSelLo,
  input  wire logic                         defaultOffsetSelHi,
  input  wire logic                         loadOffsetControl_n,
  input  wire logic                         fallThroughSelect,
  input  wire logic                         flagTimingSelect,
  input  wire logic                         zeroLatencySel,
  input  wire logic                         writeEnable_n,
  input  wire logic                         writeStrobe,
  input  wire logic                         serialEnable_n,
  input  wire logic [dfcfc_pkg::DATA_W-1:0] writeData,
  input  wire logic                         readEnable_n,
  input  wire logic                         readStrobe,
  input  wire logic                         readChipSelect_n,
  input  wire logic                         outputEnable_n,
  input  wire logic                         markRequest,
  input  wire logic                         replayRequest_n,
  output logic      [dfcfc_pkg::DATA_W-1:0] readData,
  output logic                              readDataOe,
  output logic      [1:0]                   emptyFlag_n,
  output logic      [1:0]                   fullFlag_n,
  output logic      [1:0]                   almostEmptyFlag_n,
  output logic      [1:0]                   almostFullFlag_n,
  output logic                              powerDown,
  output logic                              fallThroughMode,
  output logic                              zeroLatencyMode
);
  localparam logic [AW:0] HALF = (AW+1)'(2 ** (AW - 1));
  localparam int XW = 5 + 2 * AW;

  function automatic logic [AW:0] halfCnt(input logic [AW:0] c, input logic lsb, input logic h);
    halfCnt = (h == lsb) ? ((c + 1'b1) >> 1) : (c >> 1);
  endfunction : halfCnt

  function automatic logic [AW:0] g2b(input logic [AW:0] g);
    g2b[AW] = g[AW];
    for (int i = AW - 1; i >= 0; i--) g2b[i] = g2b[i+1] ^ g[i];
  endfunction : g2b

  logic [dfcfc_pkg::DATA_W-1:0] mem [2**AW];

  // ---- write domain (mclk)
  logic                   fullRst, wsQ, wrReq, memWe, wrFull, activity;
  logic [AW:0]            rdGrayW, rdBinW, wrCnt, wrGray;
  logic [1:0]             afComb;
  logic [AW:0]            wrPtr_reg, wrPtr_next;
  dfcfc_pkg::dfcfc_mode_e cfgMode_reg, cfgMode_next;
  logic cfgRdSync_reg, cfgRdSync_next, cfgWrSync_reg, cfgWrSync_next;
  logic cfgSerial_reg, cfgSerial_next, cfgFlagSync_reg, cfgFlagSync_next;
  logic cfgZeroLat_reg, cfgZeroLat_next, offSel_reg, offSel_next, wsPrev_reg, wsPrev_next;
  logic pd_reg, pd_next;
  logic [AW-1:0]          emptyOff_reg, emptyOff_next, fullOff_reg, fullOff_next;
  logic [1:0]             fullN_reg, fullN_next, afN_reg, afN_next;
  logic [15:0]            idle_reg, idle_next;
  logic [2:0]             defSel;

  assign fullRst  = !fullReset_n;
  assign defSel   = {loadOffsetControl_n, defaultOffsetSelHi, defaultOffsetSelLo};
  assign rdBinW   = g2b(rdGrayW);
  assign wrCnt    = wrPtr_reg - rdBinW;
  assign wrFull   = (wrCnt == (HALF << 1));
  assign wrGray   = wrPtr_reg ^ (wrPtr_reg >> 1);
  assign wrReq    = cfgWrSync_reg ? !writeEnable_n : (wsQ && !wsPrev_reg);
  assign memWe    = wrReq && loadOffsetControl_n && !wrFull;
  assign activity = !writeEnable_n || (wsQ != wsPrev_reg) || !serialEnable_n || fullRst;
  assign powerDown = pd_reg && !activity;

  dfcfc_sync #(.W(1)) uWs (.clk(mclk), .rst_n(reset_n), .d(writeStrobe), .q(wsQ));

  always_comb begin
    wrPtr_next       = wrPtr_reg;
    cfgMode_next     = cfgMode_reg;
    cfgRdSync_next   = cfgRdSync_reg;
    cfgWrSync_next   = cfgWrSync_reg;
    cfgSerial_next   = cfgSerial_reg;
    cfgFlagSync_next = cfgFlagSync_reg;
    cfgZeroLat_next  = cfgZeroLat_reg;
    emptyOff_next    = emptyOff_reg;
    fullOff_next     = fullOff_reg;
    offSel_next      = offSel_reg;
    wsPrev_next      = wsQ;
    if (fullRst) begin
      wrPtr_next       = '0;
      cfgMode_next     = dfcfc_pkg::dfcfc_mode_e'(fallThroughSelect);
      cfgRdSync_next   = readPortTimingSel;
      cfgWrSync_next   = writePortTimingSel;
      cfgFlagSync_next = flagTimingSelect;
      cfgZeroLat_next  = zeroLatencySel;
      cfgSerial_next   = loadOffsetControl_n;
      emptyOff_next    = dfcfc_pkg::DEF_OFFSET[defSel];
      fullOff_next     = dfcfc_pkg::DEF_OFFSET[defSel];
      offSel_next      = 1'b0;
    end else begin
      if (memWe) wrPtr_next = wrPtr_reg + 1'b1;
      // parallel load: empty offset, then full offset
      if (wrReq && !loadOffsetControl_n && !cfgSerial_reg) begin
        if (offSel_reg) fullOff_next = writeData[AW-1:0];
        else emptyOff_next = writeData[AW-1:0];
        offSel_next = !offSel_reg;
      end
      // serial load from the shared pin
      if (!serialEnable_n && !loadOffsetControl_n && cfgSerial_reg) begin
        {emptyOff_next, fullOff_next} = {emptyOff_reg[AW-2:0], fullOff_reg, fallThroughSelect};
      end
    end
  end

  always_comb begin
    logic [AW:0] cnt;
    cnt = '0;
    for (int h = 0; h < 2; h++) begin
      cnt = halfCnt(wrCnt, rdBinW[0], h[0]);
      fullN_next[h] = (cfgMode_reg == dfcfc_pkg::MODE_FALLTHRU) ? (cnt == HALF) : (cnt != HALF);
      afComb[h] = (HALF - cnt) > {1'b0, fullOff_reg};
    end
    afN_next = afComb;
    pd_next   = pd_reg;
    idle_next = idle_reg;
    if (activity) begin
      pd_next   = 1'b0;
      idle_next = '0;
    end else if (idle_reg == 16'(dfcfc_pkg::IDLE_CYCLES - 1)) begin
      pd_next = 1'b1;
    end else begin
      idle_next = idle_reg + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr_reg <= '0;
      cfgMode_reg <= dfcfc_pkg::MODE_STANDARD;
      {cfgRdSync_reg, cfgWrSync_reg, cfgSerial_reg, cfgFlagSync_reg} <= 4'h0;
      {cfgZeroLat_reg, offSel_reg, wsPrev_reg, pd_reg} <= 4'h0;
      emptyOff_reg <= dfcfc_pkg::DEF_OFFSET[0];
      fullOff_reg  <= dfcfc_pkg::DEF_OFFSET[0];
      fullN_reg <= 2'h3;
      afN_reg   <= 2'h3;
      idle_reg  <= '0;
    end else if (clkEn) begin
      // config only moves under full reset
      wrPtr_reg <= wrPtr_next;
      cfgMode_reg <= cfgMode_next;
      {cfgRdSync_reg, cfgWrSync_reg, cfgSerial_reg, cfgFlagSync_reg} <=
        {cfgRdSync_next, cfgWrSync_next, cfgSerial_next, cfgFlagSync_next};
      {cfgZeroLat_reg, offSel_reg, wsPrev_reg, pd_reg} <=
        {cfgZeroLat_next, offSel_next, wsPrev_next, pd_next};
      emptyOff_reg <= emptyOff_next;
      fullOff_reg  <= fullOff_next;
      fullN_reg <= fullN_next;
      afN_reg   <= afN_next;
      idle_reg  <= idle_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (clkEn && !fullRst && memWe) mem[wrPtr_reg[AW-1:0]] <= writeData;
  end

  assign fullFlag_n = fullN_reg;
  // sync mode registered, async mode follows compare directly
  assign almostFullFlag_n = cfgFlagSync_reg ? afN_reg : afComb;
  assign fallThroughMode  = (cfgMode_reg == dfcfc_pkg::MODE_FALLTHRU);
  assign zeroLatencyMode  = cfgZeroLat_reg;

  // ---- read domain (readClk)
  logic [XW-1:0] xSrc, xDst;
  logic rce, rFullRst, rFt, rRdSync, rFlagSync, rsQ, rdReq, rdEmpty;
  logic [AW-1:0] rEmptyOff, rFullOff;
  logic [AW:0]   wrGrayR, wrBinR, rdCnt;
  logic [1:0]    aeComb;
  logic [AW:0]   rdPtr_reg, rdPtr_next, mark_reg, mark_next;
  logic [dfcfc_pkg::DATA_W-1:0] dout_reg, dout_next;
  logic outValid_reg, outValid_next, outHalf_reg, outHalf_next, markValid_reg, markValid_next;
  logic rcs_reg, rsPrev_reg, rdOffSel_reg, rdOffSel_next;
  logic [1:0] emptyN_reg, emptyN_next, aeN_reg;

  assign xSrc = {clkEn, fullRst, fallThroughMode, cfgRdSync_reg, cfgFlagSync_reg,
                 emptyOff_reg, fullOff_reg};
  assign {rce, rFullRst, rFt, rRdSync, rFlagSync, rEmptyOff, rFullOff} = xDst;
  dfcfc_sync #(.W(XW))   uX  (.clk(readClk), .rst_n(reset_n), .d(xSrc), .q(xDst));
  dfcfc_sync #(.W(AW+1)) uWp (.clk(readClk), .rst_n(reset_n), .d(wrGray), .q(wrGrayR));
  dfcfc_sync #(.W(AW+1)) uRp (.clk(mclk), .rst_n(reset_n), .d(rdPtr_reg ^ (rdPtr_reg >> 1)),
                              .q(rdGrayW));
  dfcfc_sync #(.W(1))    uRs (.clk(readClk), .rst_n(reset_n), .d(readStrobe), .q(rsQ));

  assign wrBinR  = g2b(wrGrayR);
  assign rdCnt   = wrBinR - rdPtr_reg;
  assign rdEmpty = (rdCnt == '0);
  assign rdReq   = rRdSync ? !readEnable_n : (rsQ && !rsPrev_reg);

  always_comb begin
    rdPtr_next = rdPtr_reg;
    dout_next = dout_reg;
    outValid_next = outValid_reg;
    outHalf_next = outHalf_reg;
    mark_next = mark_reg;
    markValid_next = markValid_reg;
    rdOffSel_next = rdOffSel_reg;
    if (rFullRst) begin
      rdPtr_next = '0;
      dout_next = dfcfc_pkg::DOUT_RST;
      {outValid_next, markValid_next, rdOffSel_next} = 3'h0;
    end else if (!replayRequest_n) begin
      // back to the mark, or to zero
      rdPtr_next = markValid_reg ? mark_reg : '0;
      outValid_next = 1'b0;
    end else if (rdReq && !loadOffsetControl_n) begin
      dout_next = dfcfc_pkg::DATA_W'(rdOffSel_reg ? rFullOff : rEmptyOff);
      rdOffSel_next = !rdOffSel_reg;
    end else if (!rdEmpty && (rFt ? (!outValid_reg || rdReq) : rdReq)) begin
      dout_next = mem[rdPtr_reg[AW-1:0]];
      outHalf_next = rdPtr_reg[0];
      outValid_next = 1'b1;
      rdPtr_next = rdPtr_reg + 1'b1;
    end else if (rdReq) begin
      outValid_next = 1'b0;
    end
    if (markRequest && !rFullRst) begin
      mark_next = rdPtr_reg;
      markValid_next = 1'b1;
    end
    for (int h = 0; h < 2; h++) begin
      if (rFt) emptyN_next[h] = !(outValid_next && (outHalf_next == h[0]));
      else emptyN_next[h] = !replayRequest_n ? 1'b0 :
        (halfCnt(wrBinR - rdPtr_next, rdPtr_next[0], h[0]) != '0);
      aeComb[h] = halfCnt(rdCnt, rdPtr_reg[0], h[0]) >= {1'b0, rEmptyOff};
    end
  end

  always_ff @(posedge readClk or negedge reset_n) begin
    if (!reset_n) begin
      rdPtr_reg <= '0;
      mark_reg  <= '0;
      dout_reg  <= dfcfc_pkg::DOUT_RST;
      {outValid_reg, outHalf_reg, markValid_reg, rdOffSel_reg} <= 4'h0;
      {rcs_reg, rsPrev_reg} <= 2'h3;
      emptyN_reg <= 2'h0;
      aeN_reg    <= 2'h0;
    end else if (rce) begin
      rdPtr_reg <= rdPtr_next;
      mark_reg  <= mark_next;
      dout_reg  <= dout_next;
      {outValid_reg, outHalf_reg, markValid_reg, rdOffSel_reg} <=
        {outValid_next, outHalf_next, markValid_next, rdOffSel_next};
      // chip select taken on the read clock
      {rcs_reg, rsPrev_reg} <= {readChipSelect_n, rsQ};
      emptyN_reg <= emptyN_next;
      aeN_reg    <= aeComb;
    end
  end

  assign readData          = dout_reg;
  assign emptyFlag_n       = emptyN_reg;
  assign almostEmptyFlag_n = rFlagSync ? aeN_reg : aeComb;
  // async enable gated with sampled chip select outside full reset
  assign readDataOe        = !outputEnable_n && (rFullRst || !rcs_reg);

  a_pd_wake: assert property (@(posedge mclk) disable iff (!reset_n)
    (!writeEnable_n) |-> !powerDown) else $error("power-down held during activity");
  a_oe_gate: assert property (@(posedge readClk) disable iff (!reset_n)
    outputEnable_n |-> !readDataOe) else $error("output driven while disabled");
  a_rcs_sample: assert property (@(posedge readClk) disable iff (!reset_n)
    (rce && $past(rce) && !rFullRst && !outputEnable_n) |-> readDataOe == !$past(readChipSelect_n))
    else $error("chip select not one read clock late");
  a_def_offset: assert property (@(posedge mclk) disable iff (!reset_n)
    (fullRst && clkEn) |=> emptyOff_reg == dfcfc_pkg::DEF_OFFSET[$past(defSel)])
    else $error("default offset wrong");
  a_mark_rec: assert property (@(posedge readClk) disable iff (!reset_n)
    (rce && markRequest && !rFullRst) |=> mark_reg == $past(rdPtr_reg))
    else $error("mark not recorded");
  a_replay_load: assert property (@(posedge readClk) disable iff (!reset_n)
    (rce && !replayRequest_n && markValid_reg && !rFullRst) |=> rdPtr_reg == $past(mark_reg))
    else $error("replay did not reload mark");
  a_rst_clear: assert property (@(posedge readClk) disable iff (!reset_n)
    (rce && rFullRst) |=> (rdPtr_reg == '0 && readData == '0)) else $error("reset not cleared");
  a_cfg_hold: assert property (@(posedge mclk) disable iff (!reset_n)
    (!fullRst) |=> $stable({cfgMode_reg, cfgRdSync_reg, cfgWrSync_reg, cfgSerial_reg,
    cfgFlagSync_reg, cfgZeroLat_reg})) else $error("config moved outside reset");
  a_pd_exit: assert property (@(posedge mclk) disable iff (!reset_n)
    (clkEn && (!writeEnable_n || !serialEnable_n)) |=> !pd_reg) else $error("idle state kept");
endmodule : dfcfc_top

/* test/dfcfc_reader_model.sv */
/*
  Reader-side partner: clocked reads, chip select, mark and replay on readClk.
  Assumes the fifo samples its read controls on readClk rising edges.
*/
`timescale 1ns/1ps
module dfcfc_reader_model (
  input  wire logic                         readClk,
  input  wire logic [dfcfc_pkg::DATA_W-1:0] readData,
  output logic                              readEnable_n,
  output logic                              readChipSelect_n,
  output logic                              markRequest,
  output logic                              replayRequest_n
);
  initial begin
    readEnable_n     = 1'b1;
    readChipSelect_n = 1'b0;
    markRequest      = 1'b0;
    replayRequest_n  = 1'b1;
  end
  // select only moves after a read edge
  task automatic set_cs(input logic csN);
    @(posedge readClk);
    readChipSelect_n <= csN;
  endtask : set_cs
  // clocked read port only, so standard mode stays legal
  task automatic read_word(output logic [dfcfc_pkg::DATA_W-1:0] word);
    @(posedge readClk);
    readEnable_n <= 1'b0;
    @(posedge readClk);
    readEnable_n <= 1'b1;
    #1;
    word = readData;
  endtask : read_word
  // one-edge pulse; mark is active high, replay active low
  task automatic pulse(input logic isMark);
    @(posedge readClk);
    if (isMark) markRequest <= 1'b1;
    else replayRequest_n <= 1'b0;
    @(posedge readClk);
    markRequest     <= 1'b0;
    replayRequest_n <= 1'b1;
  endtask : pulse
endmodule : dfcfc_reader_model

/* test/deep_fifo_config_and_flag_control_tb.sv */
/*
  Self-checking bench: straps, flags, data path, mark/replay, power-down.
  Assumes dfcfc_top with default depth and the reader partner model.
*/
`timescale 1ns/1ps
module deep_fifo_config_and_flag_control_tb;
  localparam int DW = dfcfc_pkg::DATA_W;
  logic          mclk = 1'b0;
  logic          readClk = 1'b0;
  logic          reset_n, fullReset_n, loadN, fts, ftm, zls, wenN, oeN, offLo;
  logic [DW-1:0] wdata, rd, w [3];
  logic [DW-1:0] readData;
  logic          readDataOe, powerDown, fallThroughMode, zeroLatencyMode;
  logic          renN, csN, mark, replayN;
  logic          ce, offHi, senN;
  logic [1:0]    emptyFlag_n, fullFlag_n, almostEmptyFlag_n, almostFullFlag_n;
  int            mismatches = 0;
  int            n_tests = 0;

  always #4 mclk = ~mclk;
  // read clock off the mclk grid so edges never coincide
  initial begin
    #1.3;
    forever #80 readClk = ~readClk;
  end

  dfcfc_top dut_u (.mclk(mclk), .reset_n(reset_n), .clkEn(ce), .readClk(readClk),
    .fullReset_n(fullReset_n), .readPortTimingSel(1'b1), .writePortTimingSel(1'b1),
    .defaultOffsetSelLo(offLo), .defaultOffsetSelHi(offHi), .loadOffsetControl_n(loadN),
    .fallThroughSelect(fts), .flagTimingSelect(ftm), .zeroLatencySel(zls),
    .writeEnable_n(wenN), .writeStrobe(1'b0), .serialEnable_n(senN), .writeData(wdata),
    .readEnable_n(renN), .readStrobe(1'b0), .readChipSelect_n(csN),
    .outputEnable_n(oeN), .markRequest(mark), .replayRequest_n(replayN),
    .readData(readData), .readDataOe(readDataOe), .emptyFlag_n(emptyFlag_n),
    .fullFlag_n(fullFlag_n), .almostEmptyFlag_n(almostEmptyFlag_n),
    .almostFullFlag_n(almostFullFlag_n), .powerDown(powerDown),
    .fallThroughMode(fallThroughMode), .zeroLatencyMode(zeroLatencyMode));

  dfcfc_reader_model partner_u (.readClk(readClk), .readData(readData),
    .readEnable_n(renN), .readChipSelect_n(csN), .markRequest(mark),
    .replayRequest_n(replayN));

  function automatic logic exp_oe(input logic oe_n, input logic cs_n);
    return !oe_n && !cs_n;
  endfunction : exp_oe
  function automatic logic [DW-1:0] exp_offset(input int idx);
    return DW'(dfcfc_pkg::DEF_OFFSET[idx]);
  endfunction : exp_offset
  function automatic logic [DW-1:0] rnd();
    logic [63:0] r;
    r = {$urandom, $urandom};
    return r[DW-1:0];
  endfunction : rnd

  task automatic check(input string what, input logic [DW-1:0] seen,
                       input logic [DW-1:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wait_rd(input int n);
    repeat (n) @(posedge readClk);
    #1;
  endtask : wait_rd
  task automatic write_word(input logic [DW-1:0] d);
    @(posedge mclk);
    wenN  <= 1'b0;
    wdata <= d;
    @(posedge mclk);
    wenN  <= 1'b1;
  endtask : write_word
  task automatic full_reset(input logic ftsV, input logic ftmV, input logic zlsV,
                            input logic [1:0] sel);
    @(posedge mclk);
    fullReset_n    <= 1'b0;
    fts            <= ftsV;
    ftm            <= ftmV;
    zls            <= zlsV;
    loadN          <= 1'b0;
    {offHi, offLo} <= sel;
    // read side filters the level, so it must span several read clock edges
    repeat (3) @(posedge readClk);
    @(posedge mclk);
    fullReset_n <= 1'b1;
    @(posedge mclk);
    loadN       <= 1'b1;
    wait_rd(8);
  endtask : full_reset
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  initial begin
    #500000;
    mismatches++;
    end_of_test();
  end

  initial begin
    {reset_n, fullReset_n, fts, ftm, zls, oeN, offLo, loadN} = 8'h80;
    {ce, offHi, senN} = 3'h5;
    wenN  = 1'b1;
    wdata = 36'h0;
    void'($urandom(32'hCAAF));
    // a real falling edge, so the read domain is reset before its first edge
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    full_reset(1'b0, 1'b1, 1'b0, 2'h1);
    check("emptyFlag_n", DW'(emptyFlag_n), 36'h0);
    check("fullFlag_n", DW'(fullFlag_n), 36'h3);
    check("almostEmpty", DW'(almostEmptyFlag_n), 36'h0);
    check("almostFull", DW'(almostFullFlag_n), 36'h3);
    check("readData", readData, 36'h0);
    check("fallThrough", DW'(fallThroughMode), 36'h0);
    check("zeroLatency", DW'(zeroLatencyMode), 36'h0);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      oeN <= i[0];
      partner_u.set_cs(i[1]);
      wait_rd(4);
      check("readDataOe", DW'(readDataOe), DW'(exp_oe(i[0], i[1])));
    end
    partner_u.set_cs(1'b0);
    oeN <= 1'b0;
    $display("test output enable done");
    @(posedge mclk);
    loadN <= 1'b0;
    wait_rd(2);
    for (int i = 0; i < 2; i++) begin
      partner_u.read_word(rd);
      check("offsetRead", rd, exp_offset(1));
    end
    @(posedge mclk);
    loadN <= 1'b1;
    $display("test offsets done");
    for (int i = 0; i < 2; i++) w[i] = rnd();
    for (int i = 0; i < 2; i++) write_word(w[i]);
    wait_rd(8);
    check("emptyFlag_n", DW'(emptyFlag_n), 36'h3);
    for (int i = 0; i < 2; i++) begin
      partner_u.read_word(rd);
      check("readData", rd, w[i]);
    end
    wait_rd(8);
    check("emptyFlag_n", DW'(emptyFlag_n), 36'h0);
    // a write while frozen must not land
    @(posedge mclk);
    ce <= 1'b0;
    write_word(rnd());
    @(posedge mclk);
    ce <= 1'b1;
    wait_rd(8);
    check("clkEnFreeze", DW'(emptyFlag_n), 36'h0);
    $display("test data path done");
    partner_u.pulse(1'b1);
    for (int i = 0; i < 3; i++) w[i] = rnd();
    for (int i = 0; i < 3; i++) write_word(w[i]);
    wait_rd(8);
    for (int i = 0; i < 2; i++) begin
      partner_u.read_word(rd);
      check("readData", rd, w[i]);
    end
    partner_u.pulse(1'b0);
    wait_rd(8);
    partner_u.read_word(rd);
    check("replayData", rd, w[0]);
    $display("test replay done");
    for (int i = 0; i < 40; i++) write_word(rnd());
    wait_rd(8);
    check("almostEmpty", DW'(almostEmptyFlag_n), 36'h3);
    check("almostFull", DW'(almostFullFlag_n), 36'h3);
    $display("test almost flags done");
    @(posedge mclk);
    fts   <= 1'b1;
    offLo <= 1'b1;
    wait_rd(4);
    check("fallThrough", DW'(fallThroughMode), 36'h0);
    $display("test strap hold done");
    repeat (140) @(posedge mclk);
    #1;
    check("powerDown", DW'(powerDown), 36'h1);
    @(posedge mclk);
    wenN  <= 1'b0;
    wdata <= rnd();
    #1;
    check("powerDown", DW'(powerDown), 36'h0);
    @(posedge mclk);
    wenN <= 1'b1;
    repeat (140) @(posedge mclk);
    #1;
    check("powerDown", DW'(powerDown), 36'h1);
    @(posedge mclk);
    senN <= 1'b0;
    #1;
    check("serialWake", DW'(powerDown), 36'h0);
    @(posedge mclk);
    senN <= 1'b1;
    $display("test power down done");
    full_reset(1'b1, 1'b0, 1'b1, 2'h2);
    check("fallThrough", DW'(fallThroughMode), 36'h1);
    check("zeroLatency", DW'(zeroLatencyMode), 36'h1);
    check("readData", readData, 36'h0);
    check("outputReady", DW'(emptyFlag_n), 36'h3);
    check("inputReady", DW'(fullFlag_n), 36'h0);
    check("almostEmpty", DW'(almostEmptyFlag_n), 36'h0);
    @(posedge mclk);
    loadN <= 1'b0;
    wait_rd(2);
    partner_u.read_word(rd);
    check("offsetRead", rd, exp_offset(2));
    @(posedge mclk);
    loadN <= 1'b1;
    wait_rd(2);
    w[0] = rnd();
    write_word(w[0]);
    wait_rd(8);
    check("outputReady", DW'(emptyFlag_n), 36'h2);
    check("fallThruData", readData, w[0]);
    $display("test fall through done");
    end_of_test();
  end
endmodule : deep_fifo_config_and_flag_control_tb
